// ---- verilog/pwk_pkg.sv ----
// pwk_pkg: constants for the wake-event controller.
// assumes a 200 MHz pclk; apb register map is block-local.
package pwk_pkg;
   localparam int unsigned CLK_MHZ = 200;
   // configuration-valid deadlines
   localparam int unsigned OTP_VALID_US = 1000;
   localparam int unsigned EE_VALID_US = 16000;
   localparam int unsigned OTP_VALID_CYC = OTP_VALID_US * CLK_MHZ;
   localparam int unsigned EE_VALID_CYC = EE_VALID_US * CLK_MHZ;
   localparam int unsigned EE_BYTES = 512;
   localparam int unsigned NGPIO = 12;
   // register offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_GPIO_WAKE = 12'h004;
   localparam logic [11:0] OFS_FLAGS = 12'h008;
   localparam logic [11:0] OFS_STATUS = 12'h00C;
   localparam logic [11:0] OFS_SRC = 12'h010;
   // gpio wake register: enables low, polarity high
   localparam int unsigned GW_EN_LSB = 0;
   localparam int unsigned GW_POL_LSB = 16;
   // flags register fields
   localparam int unsigned FL_WAKE_EN = 0;
   localparam int unsigned FL_PULSE = 1;
   localparam int unsigned FL_POL_HIGH = 2;
   localparam int unsigned FL_PUSHPULL = 3;
   localparam int unsigned FL_PKT_EN = 4;
   localparam int unsigned FL_WAKEUP_FRAME_FILTER_EN = 5;
   localparam int unsigned FL_DA_EN = 6;
   localparam int unsigned FL_BCAST_EN = 7;
   localparam int unsigned FL_LINK_EN = 8;
   localparam int unsigned FL_SEL_LSB = 12;
   // ctrl register fields
   localparam int unsigned CT_CFG_DONE = 0;
   localparam int unsigned CT_HOST_SLEEP = 1;
   localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
   localparam logic [31:0] GW_RST = 32'h0000_0000;
   typedef enum logic [1:0] {
      PWK_NORMAL = 2'b00,
      PWK_LOAD = 2'b01,
      PWK_ARMED = 2'b10,
      PWK_EVENT = 2'b11
   } pwk_state_t;
endpackage

// ---- verilog/pwk_wake_ctrl.sv ----
// pwk_wake_ctrl: power wake event controller with apb register access.
// assumes configuration loader writes registers over apb before setting cfg_done;
// pin inputs arrive asynchronous and are synchronised here.
//
// Overview of operation
// RULE_01 - wake only when self powered with eeprom
// RULE_02 - drive wake event output on wake
// RULE_03 - sample stay-asleep select at clear release
// RULE_04 - select one stays wake mode, zero normal
// RULE_05 - otp mode output valid within 1 ms
// RULE_06 - eeprom load valid below 16 ms
// RULE_07 - controller ignores output during config load
// RULE_08 - gpio wakes only when enable bit set
// RULE_09 - per-gpio polarity picks wake level
// RULE_10 - remote-wake frame raises wake event
// RULE_11 - wakeup frame filter match raises event
// RULE_12 - destination address match raises event
// RULE_13 - broadcast frame raises event
// RULE_14 - link partner detect raises event
// RULE_15 - wake enable flag gates wake mode
// RULE_16 - reset or power-on reloads eeprom contents
// RULE_17 - power-on with select high enters wake mode
// RULE_18 - ethernet keeps negotiated speed in wake mode
// RULE_19 - controller powers bus, sets select, clears
// RULE_20 - no config needs software-programmed wake sources
// RULE_21 - encodings: level zero, high one, push-pull one
// RULE_22 - link wake routed via gpio or irq
// RULE_23 - level output held until clear
`timescale 1ns/1ps
module pwk_wake_ctrl #(
   parameter int unsigned OTP_CYC = pwk_pkg::OTP_VALID_CYC,
   parameter int unsigned EE_CYC = pwk_pkg::EE_VALID_CYC,
   parameter int unsigned PULSE_CYC = 16
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // controller pins
   input wire logic wake_clear_in,
   input wire logic stay_asleep_select,
   input wire logic bus_power_detect,
   input wire logic power_source_select,
   input wire logic eeprom_present,
   output logic wake_event_out,
   output logic wake_event_oe_n,
   // wake sources
   input wire logic [pwk_pkg::NGPIO-1:0] gpio_in,
   input wire logic transceiver_irq_in_n,
   input wire logic rx_remote_wake_hit,
   input wire logic rx_wakeup_frame_filter_hit,
   input wire logic rx_da_match_hit,
   input wire logic rx_broadcast_hit,
   // to the mac
   output logic hold_link_speed,
   output logic cfg_reload_req
);
   import pwk_pkg::*;

   initial begin
      if (OTP_CYC < 1 || EE_CYC < OTP_CYC || PULSE_CYC < 1 || PULSE_CYC > 65535) begin
         $error("pwk_wake_ctrl: bad timing parameters");
      end
   end

   // pin synchronisers: stage one is read only by stage two
   logic [NGPIO+4:0] sync1_q, sync2_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {eeprom_present, power_source_select, bus_power_detect,
                     transceiver_irq_in_n, stay_asleep_select, gpio_in};
         sync2_q <= sync1_q;
      end
   end
   wire [NGPIO-1:0] gpio_s = sync2_q[NGPIO-1:0];
   wire mode_s = sync2_q[NGPIO];
   wire irq_n_s = sync2_q[NGPIO+1];
   wire bus_pwr_s = sync2_q[NGPIO+2];
   wire self_pwr_s = sync2_q[NGPIO+3];
   wire ee_s = sync2_q[NGPIO+4];

   // the clear pin sync-resets state and ctrl but not flags, gpio wake or sources; its release edge samples the select
   logic clr1_q, clr2_q, clr3_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clr1_q <= 1'b0;
         clr2_q <= 1'b0;
         clr3_q <= 1'b0;
      end else begin
         clr1_q <= wake_clear_in;
         clr2_q <= clr1_q;
         clr3_q <= clr2_q;
      end
   end
   wire clr_active = clr2_q;
   wire clr_release = clr3_q && !clr2_q;

   // registers
   logic [31:0] flags_q, gwake_q, src_q;
   logic [1:0] ctrl_q;
   pwk_state_t state_q, state_d;
   logic mode_latched_q;
   // power-on capture waits until the select has passed both sync stages
   logic [2:0] por_pending_q;
   logic [31:0] load_cnt_q;
   logic [15:0] pulse_cnt_q;
   logic out_q;

   wire wake_en = flags_q[FL_WAKE_EN];
   wire pulse_mode = flags_q[FL_PULSE]; // zero selects level RULE_21
   wire pol_high = flags_q[FL_POL_HIGH]; // one is active high RULE_21
   wire push_pull = flags_q[FL_PUSHPULL]; // one is push-pull RULE_21
   wire cfg_done = ctrl_q[CT_CFG_DONE];
   wire allowed = self_pwr_s && ee_s; // RULE_01
   wire [NGPIO-1:0] gw_en = gwake_q[GW_EN_LSB +: NGPIO];
   wire [NGPIO-1:0] gw_pol = gwake_q[GW_POL_LSB +: NGPIO];
   wire [NGPIO-1:0] gsel = NGPIO'(1) << flags_q[FL_SEL_LSB +: 4];
   // the output gpio is reserved and cannot wake itself
   wire [NGPIO-1:0] gpio_hit = gw_en & ~gsel & ~(gpio_s ^ gw_pol); // RULE_08 RULE_09
   wire [8:0] srcs = {
      !irq_n_s && flags_q[FL_LINK_EN], // RULE_14 RULE_22
      rx_broadcast_hit && flags_q[FL_BCAST_EN], // RULE_13
      rx_da_match_hit && flags_q[FL_DA_EN], // RULE_12
      rx_wakeup_frame_filter_hit && flags_q[FL_WAKEUP_FRAME_FILTER_EN], // RULE_11
      rx_remote_wake_hit && flags_q[FL_PKT_EN], // RULE_10
      |gpio_hit, 3'b000};
   wire wake_hit = |srcs;
   wire load_tmo = load_cnt_q >= (ee_s ? EE_CYC : OTP_CYC); // RULE_05 RULE_06

   // apb decode
   wire apb_wr = psel && penable && pwrite;
   wire apb_rd = psel && !pwrite;
   wire hit_ctrl = paddr == OFS_CTRL;
   wire hit_gw = paddr == OFS_GPIO_WAKE;
   wire hit_fl = paddr == OFS_FLAGS;
   wire hit_st = paddr == OFS_STATUS;
   wire hit_src = paddr == OFS_SRC;
   wire mapped = hit_ctrl || hit_gw || hit_fl || hit_st || hit_src;
   wire [31:0] status_w = {24'h00_0000, 1'b0, bus_pwr_s, allowed, mode_latched_q,
                           out_q, state_q, cfg_done};
   wire [31:0] rd_mux = hit_ctrl ? {30'h0000_0000, ctrl_q} :
                        hit_gw ? gwake_q :
                        hit_fl ? flags_q :
                        hit_st ? status_w :
                        hit_src ? src_q : 32'h0000_0000;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (apb_rd && !penable) begin
         prdata <= rd_mux;
      end
   end

   // state machine
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         PWK_NORMAL: begin
            if (ctrl_q[CT_HOST_SLEEP] && wake_en && allowed) begin
               state_d = PWK_ARMED;
            end
         end
         PWK_LOAD: begin
            if (cfg_done || load_tmo) begin
               // power-on with select high enters wake mode
               state_d = (mode_latched_q && wake_en && allowed) ? PWK_ARMED
                         : PWK_NORMAL; // RULE_04 RULE_15 RULE_17
            end
         end
         PWK_ARMED: begin
            if (!wake_en || !allowed) begin
               state_d = PWK_NORMAL; // RULE_15
            end else if (wake_hit) begin
               state_d = PWK_EVENT;
            end
         end
         PWK_EVENT: state_d = PWK_EVENT; // only clear leaves
      endcase
      if (clr_active) begin
         state_d = PWK_LOAD; // RULE_16
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= PWK_LOAD;
         por_pending_q <= 3'b001;
         mode_latched_q <= 1'b0;
         load_cnt_q <= '0;
      end else begin
         state_q <= state_d;
         por_pending_q <= {por_pending_q[1:0], 1'b0};
         if (clr_release || por_pending_q[2]) begin
            mode_latched_q <= mode_s; // RULE_03 RULE_17
         end
         load_cnt_q <= (state_q == PWK_LOAD && !clr_active) ? load_cnt_q + 32'd1 : '0;
      end
   end

   // config load: loader (or software) rewrites registers, cfg_done ends it
   assign cfg_reload_req = state_q == PWK_LOAD; // RULE_16

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 2'b00;
         flags_q <= FLAGS_RST;
         gwake_q <= GW_RST;
      end else begin
         if (clr_active) begin
            ctrl_q[CT_CFG_DONE] <= 1'b0;
            ctrl_q[CT_HOST_SLEEP] <= 1'b0;
         end else if (apb_wr && hit_ctrl) begin
            ctrl_q <= pwdata[1:0];
         end else if (state_q != PWK_NORMAL) begin
            ctrl_q[CT_HOST_SLEEP] <= 1'b0;
         end
         if (apb_wr && hit_fl) begin
            flags_q <= pwdata;
         end
         if (apb_wr && hit_gw) begin
            gwake_q <= pwdata;
         end
      end
   end

   // sticky wake sources, set wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_q <= 32'h0000_0000;
      end else begin
         src_q <= ((apb_wr && hit_src) ? (src_q & ~pwdata) : src_q)
                  | ((state_q == PWK_ARMED) ? {23'h00_0000, srcs} : 32'h0000_0000);
      end
   end

   // output drive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_cnt_q <= 16'h0000;
         out_q <= 1'b0;
      end else begin
         if (state_q == PWK_ARMED && state_d == PWK_EVENT) begin
            pulse_cnt_q <= 16'(PULSE_CYC);
         end else if (pulse_cnt_q != 16'h0000) begin
            pulse_cnt_q <= pulse_cnt_q - 16'h0001;
         end
         if (state_q == PWK_EVENT) begin
            out_q <= pulse_mode ? (pulse_cnt_q != 16'h0000) : 1'b1; // RULE_02 RULE_23
         end else begin
            out_q <= 1'b0;
         end
      end
   end

   // undriven during load so polarity cannot glitch the controller
   wire drive_valid = state_q != PWK_LOAD; // RULE_07
   wire level = pol_high ? out_q : !out_q;
   assign wake_event_out = drive_valid ? level : 1'b0;
   // open drain drives only the low level, whichever level is active
   assign wake_event_oe_n = !drive_valid || (!push_pull && level);
   assign hold_link_speed = state_q == PWK_ARMED || state_q == PWK_EVENT; // RULE_18
endmodule // pwk_wake_ctrl

// ---- verification/pwk_wake_ctrl_chk.sv ----
// pwk_wake_ctrl_chk: port assertions for the wake-event controller.
// assumes bind into pwk_wake_ctrl; flags and gpio wake are rebuilt from apb writes.
`timescale 1ns/1ps
module pwk_wake_ctrl_chk import pwk_pkg::*; #(
   parameter int unsigned OTP_CYC = 50,
   parameter int unsigned EE_CYC = 100
) (
   // clock, reset and apb
   input wire logic pclk, presetn, psel, penable, pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // pins and status
   input wire logic wake_clear_in, eeprom_present, wake_event_out, wake_event_oe_n,
   input wire logic [pwk_pkg::NGPIO-1:0] gpio_in,
   input wire logic transceiver_irq_in_n, rx_remote_wake_hit, rx_wakeup_frame_filter_hit,
   input wire logic rx_da_match_hit, rx_broadcast_hit, hold_link_speed, cfg_reload_req
);
   logic [31:0] fl_q, gw_q;
   int lc_q;
   logic ev, rxh, ah;
   wire wr = psel && penable && pwrite;
   wire [11:0] gmask = ~(12'h001 << fl_q[15:12]);
   // active means driven at the configured level; load hides the output
   assign ev = !cfg_reload_req && !wake_event_oe_n && wake_event_out == fl_q[FL_POL_HIGH];
   assign rxh = (rx_remote_wake_hit & fl_q[4]) | (rx_wakeup_frame_filter_hit & fl_q[5])
      | (rx_da_match_hit & fl_q[6]) | (rx_broadcast_hit & fl_q[7]);
   assign ah = |((gpio_in ~^ gw_q[27:16]) & gw_q[11:0] & gmask)
      | (!transceiver_irq_in_n & fl_q[8]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fl_q <= FLAGS_RST;
         gw_q <= GW_RST;
         lc_q <= 0;
      end else begin
         if (wr && paddr == OFS_FLAGS) fl_q <= pwdata;
         if (wr && paddr == OFS_GPIO_WAKE) gw_q <= pwdata;
         lc_q <= (cfg_reload_req && !wake_clear_in) ? lc_q + 1 : 0;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rx_wake;
      hold_link_speed && fl_q[0] && !fl_q[1] && !wake_clear_in && rxh |-> ##[1:3] ev;
   endproperty
   a_rx_wake: assert property (p_rx_wake) else $error("frame hit missed");
   property p_pin_wake;
      hold_link_speed && fl_q[0] && !fl_q[1] && !wake_clear_in && ah && $past(ah)
         && $past(ah, 2) |-> ##[1:4] ev;
   endproperty
   a_pin_wake: assert property (p_pin_wake) else $error("pin wake missed");
   property p_quiet; !hold_link_speed |-> !ev; endproperty
   a_quiet: assert property (p_quiet) else $error("event outside wake mode");
   property p_hold; ev && !fl_q[FL_PULSE] && !wake_clear_in |=> ev; endproperty
   a_hold: assert property (p_hold) else $error("level event dropped");
   property p_reload; $rose(wake_clear_in) |-> ##[1:4] cfg_reload_req; endproperty
   a_reload: assert property (p_reload) else $error("clear gave no reload");
   property p_load_low; cfg_reload_req |-> !wake_event_out; endproperty
   a_load_low: assert property (p_load_low) else $error("output active in load");
   property p_otp; !eeprom_present |-> lc_q <= OTP_CYC + 8; endproperty
   a_otp: assert property (p_otp) else $error("otp load too long");
   property p_ee; lc_q <= EE_CYC + 8; endproperty
   a_ee: assert property (p_ee) else $error("eeprom load too long");
   property p_speed; ev |-> hold_link_speed; endproperty
   a_speed: assert property (p_speed) else $error("speed not held in event");
endmodule // pwk_wake_ctrl_chk
bind pwk_wake_ctrl pwk_wake_ctrl_chk #(.OTP_CYC(OTP_CYC), .EE_CYC(EE_CYC)) chk_inst (.pclk,
   .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .wake_clear_in, .eeprom_present,
   .wake_event_out, .wake_event_oe_n, .gpio_in, .transceiver_irq_in_n, .rx_remote_wake_hit,
   .rx_wakeup_frame_filter_hit, .rx_da_match_hit, .rx_broadcast_hit, .hold_link_speed,
   .cfg_reload_req);

// ---- verification/pwk_ec_model.sv ----
// pwk_ec_model: embedded controller that clears wake events and picks the next mode.
// assumes the bench calls clear_ev; it never samples the output while config loads.
`timescale 1ns/1ps
module pwk_ec_model (
   // clock
   input wire logic pclk,
   // pins to the wake controller
   output logic wake_clear_in,
   output logic stay_asleep_select,
   output logic bus_power_detect
);
   initial begin
      wake_clear_in = 1'b0;
      stay_asleep_select = 1'b0;
      bus_power_detect = 1'b0;
   end
   // slow models a lingering controller; select stays put across the release
   task automatic clear_ev(input logic s, input int slow);
      @(posedge pclk);
      bus_power_detect <= 1'b1;
      stay_asleep_select <= s;
      repeat (slow + 1) @(posedge pclk);
      wake_clear_in <= 1'b1;
      repeat (4) @(posedge pclk);
      wake_clear_in <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
endmodule // pwk_ec_model

// ---- verification/pwk_wake_ctrl_tb.sv ----
// pwk_wake_ctrl_tb: table of wake sources, then select, load, reset and power-on cases.
// assumes short load timeouts of 50 and 100 cycles.
`timescale 1ns/1ps
module pwk_wake_ctrl_tb;
   import pwk_pkg::*;
   typedef struct {logic [31:0] fl, gw; logic [11:0] gv; logic [2:0] src; logic out;} pwk_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, power_source_select;
   logic [11:0] paddr, gpio_in;
   logic [31:0] pwdata, prdata, rd;
   logic wake_clear_in, stay_asleep_select, bus_power_detect, eeprom_present, wake_event_out;
   logic wake_event_oe_n, transceiver_irq_in_n, hold_link_speed, cfg_reload_req;
   logic rx_remote_wake_hit, rx_wakeup_frame_filter_hit, rx_da_match_hit, rx_broadcast_hit;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   // flags, gpio wake, pin levels, source (7 = pins only), output level
   pwk_row_t rows [13] = '{
      '{32'h0000_001D, 32'h0000_0000, 12'h000, 3'h0, 1'b1},
      '{32'h0000_002D, 32'h0000_0000, 12'h000, 3'h1, 1'b1},
      '{32'h0000_004D, 32'h0000_0000, 12'h000, 3'h2, 1'b1},
      '{32'h0000_008D, 32'h0000_0000, 12'h000, 3'h3, 1'b1},
      '{32'h0000_010D, 32'h0000_0000, 12'h000, 3'h4, 1'b1},
      '{32'h0000_B00D, 32'h0001_0001, 12'h001, 3'h7, 1'b1},
      '{32'h0000_B00D, 32'h0000_0001, 12'h000, 3'h7, 1'b1},
      '{32'h0000_B00D, 32'h0001_0000, 12'h001, 3'h7, 1'b0},
      '{32'h0000_000D, 32'h0001_0001, 12'h001, 3'h7, 1'b0},
      '{32'h0000_000D, 32'h0000_0000, 12'h000, 3'h3, 1'b0},
      '{32'h0000_008C, 32'h0000_0000, 12'h000, 3'h3, 1'b0},
      '{32'h0000_008F, 32'h0000_0000, 12'h000, 3'h3, 1'b0},
      '{32'h0000_0089, 32'h0000_0000, 12'h000, 3'h3, 1'b0}};
   pwk_wake_ctrl #(.OTP_CYC(50), .EE_CYC(100)) pwk_wake_ctrl_inst (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wake_clear_in,
      .stay_asleep_select, .bus_power_detect, .power_source_select, .eeprom_present,
      .wake_event_out, .wake_event_oe_n, .gpio_in, .transceiver_irq_in_n, .rx_remote_wake_hit,
      .rx_wakeup_frame_filter_hit, .rx_da_match_hit, .rx_broadcast_hit, .hold_link_speed,
      .cfg_reload_req);
   pwk_ec_model pwk_ec_model_inst (.pclk, .wake_clear_in, .stay_asleep_select, .bus_power_detect);
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic arm(input logic s, input logic [31:0] fl, input logic [31:0] gw);
      pwk_ec_model_inst.clear_ev(s, 2);
      chk(cfg_reload_req, 1);
      chk(wake_event_out, 0);
      apb(1'b1, OFS_GPIO_WAKE, gw);
      apb(1'b1, OFS_FLAGS, fl);
      apb(1'b1, OFS_CTRL, 32'h0000_0001);
      repeat (3) @(posedge pclk);
      #1;
   endtask
   task automatic fire(input logic [2:0] s);
      @(posedge pclk);
      rx_remote_wake_hit <= (s == 3'h0);
      rx_wakeup_frame_filter_hit <= (s == 3'h1);
      rx_da_match_hit <= (s == 3'h2);
      rx_broadcast_hit <= (s == 3'h3);
      transceiver_irq_in_n <= (s != 3'h4);
      @(posedge pclk);
      {rx_remote_wake_hit, rx_wakeup_frame_filter_hit, rx_da_match_hit} <= 3'h0;
      rx_broadcast_hit <= 1'b0;
      // past any 16-cycle pulse, so only a held level survives
      repeat (24) @(posedge pclk);
      transceiver_irq_in_n <= 1'b1;
      #1;
   endtask
   task automatic report_and_stop();
      $display("errors %0d checks %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         report_and_stop();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, rx_remote_wake_hit, rx_wakeup_frame_filter_hit} = 6'h00;
      {rx_da_match_hit, rx_broadcast_hit, paddr, pwdata, gpio_in} = 0;
      {power_source_select, eeprom_present, transceiver_irq_in_n} = 3'h7;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1;
      chk(cfg_reload_req, 1);
      apb(1'b0, OFS_FLAGS, 32'h0000_0000);
      chk(rd, FLAGS_RST);
      apb(1'b0, 12'h020, 32'h0000_0000);
      chk({rd[30:0], err}, 32'h0000_0001);
      foreach (rows[i]) begin
         gpio_in <= rows[i].gv;
         arm(1'b1, rows[i].fl, rows[i].gw);
         chk(hold_link_speed, rows[i].fl[FL_WAKE_EN]);
         fire(rows[i].src);
         chk(wake_event_out, rows[i].out);
         chk(wake_event_oe_n, 0);
      end
      apb(1'b0, OFS_SRC, 32'h0000_0000);
      chk(rd, 32'h0000_01F8);
      arm(1'b0, 32'h0000_008D, 32'h0000_0000);
      chk(hold_link_speed, 0);
      fire(3'h3);
      chk(wake_event_out, 0);
      eeprom_present <= 1'b0;
      pwk_ec_model_inst.clear_ev(1'b1, 0);
      repeat (60) @(posedge pclk);
      #1;
      chk({cfg_reload_req, hold_link_speed}, 0);
      eeprom_present <= 1'b1;
      pwk_ec_model_inst.clear_ev(1'b1, 9);
      repeat (110) @(posedge pclk);
      #1;
      chk(cfg_reload_req, 0);
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, OFS_FLAGS, 32'h0000_008D);
      apb(1'b0, OFS_FLAGS, 32'h0000_0000);
      chk(rd, 32'h0000_008D);
      apb(1'b1, OFS_CTRL, 32'h0000_0001);
      repeat (3) @(posedge pclk);
      #1;
      chk(hold_link_speed, 1);
      fire(3'h3);
      chk(wake_event_out, 1);
      report_and_stop();
   end
endmodule // pwk_wake_ctrl_tb
